/* sim/switch_bank.sv */
// debounced user switches that drive the key inputs of the block
`timescale 1ns/1ps
module switch_bank (
  input wire logic pclk,
  output stopwatch_pkg::keys_t keys
);
  import stopwatch_pkg::*;
  initial keys = '0;
  // one clean press: high four cycles, then released low four cycles
  task automatic press(input int idx);
    @(posedge pclk);
    keys[idx] <= 1'b1;
    repeat (4) @(posedge pclk);
    keys[idx] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  // on-demand viewing: two display presses a fixed gap apart
  task automatic double_press(input int gap);
    press(2);
    repeat (gap) @(posedge pclk);
    press(2);
  endtask
endmodule

/* sim/testbench.sv */
// self-checking bench for the stopwatch and clock control block
`timescale 1ns/1ps
module testbench;
  import stopwatch_pkg::*;
  localparam int K_RUN = 4;
  localparam int K_RST = 3;
  localparam int K_DSP = 2;
  localparam int K_MIN = 1;
  localparam int K_HR = 0;
  localparam int SCAN_SLOT = 2;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  keys_t keys;
  mode_sel_t mode_sel;
  logic [7:0] digit_strobe;
  logic [6:0] segments;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] a, b, s;
  logic e;

  stopwatch_clock_mode_control #(.TICK_CYCLES(4), .SLOT_CYCLES(SCAN_SLOT))
    stopwatch_clock_mode_control_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .keys(keys),
    .mode_sel(mode_sel), .digit_strobe(digit_strobe), .segments(segments));
  switch_bank switch_bank_i (.pclk(pclk), .keys(keys));

  // ==========================================================
  // clock and hang guard
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches = mismatches + 1;
      report_and_stop();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic report_and_stop();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    logic er;
    apb(1'b0, ad, 32'h0, d, er);
  endtask
  task automatic stat(input string what, input int idx, input logic exp);
    logic [31:0] d;
    rd(STATUS_OFFSET, d);
    chk(what, {31'b0, exp}, {31'b0, d[idx]});
  endtask
  task automatic holds(input string what, input logic cond);
    chk(what, 32'h1, {31'b0, cond});
  endtask
  task automatic set_mode(input logic [2:0] m);
    @(posedge pclk);
    mode_sel <= m;
    repeat (4) @(posedge pclk);
  endtask
  task automatic wait_cy(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [2:0] sels [4] = '{3'b000, 3'b100, 3'b010, 3'b001};
    rd(COUNT_OFFSET, a);
    chk("count", 32'h0, a);
    rd(SHOWN_OFFSET, a);
    chk("shown", 32'h0, a);
    rd(STATUS_OFFSET, a);
    chk("status", 32'h4, a);
    apb(1'b0, 8'h10, 32'h0, a, e);
    chk("unmapped err", 32'h1, {31'b0, e});
    chk("unmapped data", 32'h0, a);
    apb(1'b1, COUNT_OFFSET, 32'h12345678, a, e);
    rd(COUNT_OFFSET, a);
    chk("count write ignored", 32'h0, a);
    for (int m = 0; m < 4; m++)
    begin
      set_mode(sels[m]);
      rd(STATUS_OFFSET, a);
      chk("mode", m, {30'b0, a[STAT_MODE_LSB +: 2]});
    end
    set_mode(3'b000);
  endtask
  task automatic t_scan();
    int on0;
    int hi;
    int segbad;
    int gap;
    on0 = 0;
    hi = 0;
    segbad = 0;
    gap = 0;
    for (int i = 0; i < 64; i++)
    begin
      @(negedge pclk);
      on0 += (digit_strobe[0] === 1'b1);
      hi += (digit_strobe[7:2] !== 6'h0);
      segbad += (digit_strobe[1:0] !== 2'b00 && segments !== 7'h3f);
    end
    // measure one full scan from a rise of the units strobe to the next
    while (digit_strobe[0] === 1'b1)
      @(negedge pclk);
    while (digit_strobe[0] !== 1'b1)
      @(negedge pclk);
    do
    begin
      @(negedge pclk);
      gap++;
    end
    while (digit_strobe[0] === 1'b1);
    do
    begin
      @(negedge pclk);
      gap++;
    end
    while (digit_strobe[0] !== 1'b1);
    chk("units strobe cycles", 32'd8, on0);
    chk("units strobe period", 32'(8 * SCAN_SLOT), gap);
    chk("blank upper strobes", 32'd0, hi);
    chk("zero digit segments", 32'd0, segbad);
  endtask
  task automatic t_steps();
    repeat (3) switch_bank_i.press(K_MIN);
    repeat (2) switch_bank_i.press(K_HR);
    rd(COUNT_OFFSET, a);
    chk("stepped count", 32'h02030000, a);
    apb(1'b1, KEYCTL_OFFSET, 32'h8, a, e);
    rd(COUNT_OFFSET, a);
    chk("soft reset count", 32'h0, a);
  endtask
  task automatic t_inter();
    set_mode(3'b001);
    switch_bank_i.press(K_RUN);
    wait_cy(40);
    switch_bank_i.press(K_RST);
    stat("locked", STAT_LOCKED_BIT, 1'b1);
    rd(COUNT_OFFSET, a);
    holds("reset ignored", a != 32'h0);
    switch_bank_i.press(K_RUN);
    rd(COUNT_OFFSET, a);
    wait_cy(20);
    rd(COUNT_OFFSET, b);
    rd(SHOWN_OFFSET, s);
    chk("halted count", a, b);
    chk("halted shown", a, s);
    switch_bank_i.press(K_RUN);
    wait_cy(40);
    rd(COUNT_OFFSET, b);
    holds("resumed from total", b > a);
    switch_bank_i.press(K_DSP);
    stat("blanked", STAT_LIT_BIT, 1'b0);
    t_dark();
    switch_bank_i.double_press(10);
    stat("on then off", STAT_LIT_BIT, 1'b0);
    set_mode(3'b000);
    switch_bank_i.press(K_RST);
    rd(STATUS_OFFSET, a);
    chk("status after reset", 32'h4, a);
  endtask
  task automatic t_dark();
    int hi;
    hi = 0;
    for (int i = 0; i < 20; i++)
    begin
      @(negedge pclk);
      hi += (digit_strobe != 8'h0);
    end
    chk("dark strobes", 32'd0, hi);
  endtask
  task automatic t_leg();
    switch_bank_i.press(K_RUN);
    wait_cy(60);
    rd(COUNT_OFFSET, a);
    switch_bank_i.press(K_RUN);
    rd(SHOWN_OFFSET, s);
    rd(COUNT_OFFSET, b);
    holds("leg captured", s >= a);
    holds("leg cleared", b < s);
    stat("still running", STAT_RUNNING_BIT, 1'b1);
    stat("leg held", STAT_HOLD_BIT, 1'b1);
    switch_bank_i.press(K_DSP);
    stat("hold dropped", STAT_HOLD_BIT, 1'b0);
    stat("lit", STAT_LIT_BIT, 1'b1);
    switch_bank_i.press(K_DSP);
    stat("still lit", STAT_LIT_BIT, 1'b1);
    switch_bank_i.press(K_RST);
    wait_cy(10);
    rd(COUNT_OFFSET, a);
    rd(SHOWN_OFFSET, s);
    chk("count cleared", 32'h0, a);
    chk("shown cleared", 32'h0, s);
  endtask
  task automatic t_cumul();
    set_mode(3'b010);
    switch_bank_i.press(K_RUN);
    stat("started", STAT_RUNNING_BIT, 1'b1);
    rd(SHOWN_OFFSET, a);
    wait_cy(12);
    rd(SHOWN_OFFSET, b);
    holds("shown live", b > a);
    switch_bank_i.press(K_RUN);
    rd(SHOWN_OFFSET, a);
    wait_cy(20);
    rd(SHOWN_OFFSET, s);
    rd(COUNT_OFFSET, b);
    chk("shown frozen", a, s);
    holds("counter runs on", b > a);
    switch_bank_i.press(K_RUN);
    rd(SHOWN_OFFSET, s);
    rd(COUNT_OFFSET, b);
    holds("total loaded", s > a);
    holds("not cleared", b >= s);
    switch_bank_i.press(K_DSP);
    stat("caught up", STAT_HOLD_BIT, 1'b0);
    stat("lit", STAT_LIT_BIT, 1'b1);
    switch_bank_i.press(K_RST);
  endtask
  task automatic t_single();
    set_mode(3'b100);
    switch_bank_i.press(K_RUN);
    wait_cy(40);
    switch_bank_i.press(K_RUN);
    rd(COUNT_OFFSET, a);
    switch_bank_i.press(K_RUN);
    rd(COUNT_OFFSET, b);
    holds("restart cleared", b < a);
    stat("restarted", STAT_RUNNING_BIT, 1'b1);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    mode_sel = 3'b000;
    wait_cy(20);
    presetn <= 1'b1;
    wait_cy(2);
    t_reset();
    t_scan();
    t_steps();
    t_inter();
    t_leg();
    t_cumul();
    t_single();
    report_and_stop();
  end
endmodule

/* verilog/key_events.sv */
// switch input synchronizers with rising-edge event detection
`timescale 1ns/1ps
module key_events #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("key_events width must be at least one");
    end
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_key
      logic meta;
      logic stable;
      logic prev;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          meta <= 1'b0;
          stable <= 1'b0;
          prev <= 1'b0;
        end
        else
        begin
          meta <= raw[i];
          stable <= meta;
          prev <= stable;
        end
      end
      assign level[i] = stable;
      assign rise[i] = stable & ~prev;
    end
  endgenerate
endmodule

/* verilog/stopwatch_clock_mode_control.sv */
// multi-mode stopwatch and 24-hour clock control with apb status access
`timescale 1ns/1ps
module stopwatch_clock_mode_control #(
  parameter int TICK_CYCLES = stopwatch_pkg::TICK_CYCLES,
  parameter int SLOT_CYCLES = stopwatch_pkg::SLOT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire stopwatch_pkg::keys_t keys,
  input wire stopwatch_pkg::mode_sel_t mode_sel,
  output logic [7:0] digit_strobe,
  output logic [6:0] segments
);
  import stopwatch_pkg::*;

  localparam int KEY_BITS = $bits(keys_t);
  localparam int SEL_BITS = $bits(mode_sel_t);

  generate
    if (TICK_CYCLES < 2 || SLOT_CYCLES < 1)
    begin : g_bad_timing
      $error("tick or slot cycle count too small");
    end
  endgenerate

  // ==========================================================
  // decoding functions
  function automatic mode_t decode_mode(input mode_sel_t s);
    mode_t m;
    if (s.single_sel)
      m = MODE_SINGLE;
    else if (s.cumulative_sel)
      m = MODE_CUMULATIVE;
    else if (s.interrupted_sel)
      m = MODE_INTERRUPTED;
    else
      m = MODE_LEG;
    return m;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return a == KEYCTL_OFFSET || a == STATUS_OFFSET || a == COUNT_OFFSET
      || a == SHOWN_OFFSET;
  endfunction

  function automatic logic [6:0] seg_decode(input logic [3:0] d);
    logic [6:0] s;
    unique case (d)
      4'h0: s = 7'h3f;
      4'h1: s = 7'h06;
      4'h2: s = 7'h5b;
      4'h3: s = 7'h4f;
      4'h4: s = 7'h66;
      4'h5: s = 7'h6d;
      4'h6: s = 7'h7d;
      4'h7: s = 7'h07;
      4'h8: s = 7'h7f;
      4'h9: s = 7'h6f;
      default: s = 7'h00;
    endcase
    return s;
  endfunction

  // ==========================================================
  // switch inputs
  logic [KEY_BITS+SEL_BITS-1:0] sync_level;
  logic [KEY_BITS+SEL_BITS-1:0] sync_rise;
  keys_t pin_ev;
  mode_sel_t mode_lvl;
  mode_t mode;

  key_events #(.WIDTH(KEY_BITS + SEL_BITS)) u_keys (
    .pclk(pclk),
    .presetn(presetn),
    .raw({keys, mode_sel}),
    .level(sync_level),
    .rise(sync_rise)
  );

  assign pin_ev = keys_t'(sync_rise[KEY_BITS+SEL_BITS-1:SEL_BITS]);
  assign mode_lvl = mode_sel_t'(sync_level[SEL_BITS-1:0]);
  assign mode = decode_mode(mode_lvl);

  // ==========================================================
  // apb slave
  logic setup_phase;
  logic access_phase;
  keys_t soft_ev;
  keys_t ev;

  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign pready = 1'b1;
  assign pslverr = access_phase & ~is_mapped(paddr);
  assign soft_ev = (access_phase && pwrite && paddr == KEYCTL_OFFSET)
    ? keys_t'(pwdata[KEY_BITS-1:0]) : '0;
  assign ev = pin_ev | soft_ev;

  // ==========================================================
  // mode control
  logic running;
  logic hold;
  logic lit;
  logic reset_locked;
  logic timed;
  time_t held;
  time_t count;
  time_t shown;
  logic reset_ok;
  logic run_ev;
  logic disp_ev;
  logic counter_clear;
  logic tick;
  logic [31:0] presc;

  assign reset_ok = ev.reset_key & ~(mode == MODE_INTERRUPTED & reset_locked);
  assign run_ev = ev.run_halt_key & ~reset_ok;
  assign disp_ev = ev.display_key & ~reset_ok;
  // single-cycle clear, far shorter than one count step
  assign counter_clear = reset_ok
    | (run_ev & mode == MODE_LEG & running)
    | (run_ev & mode == MODE_SINGLE & ~running & timed);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      running <= 1'b0;
    else if (reset_ok)
      running <= 1'b0;
    else if (run_ev)
    begin
      unique case (mode)
        MODE_LEG: running <= 1'b1;
        MODE_CUMULATIVE: running <= 1'b1;
        MODE_SINGLE: running <= ~running;
        MODE_INTERRUPTED: running <= ~running;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold <= 1'b0;
    else if (reset_ok)
      hold <= 1'b0;
    else if (run_ev && (mode == MODE_LEG || mode == MODE_CUMULATIVE))
      hold <= running;
    else if (disp_ev && (mode == MODE_LEG || mode == MODE_CUMULATIVE))
      hold <= 1'b0;
    else if (mode == MODE_SINGLE || mode == MODE_INTERRUPTED)
      hold <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      held <= '0;
    else if (run_ev && running && (mode == MODE_LEG || mode == MODE_CUMULATIVE))
      held <= count;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lit <= LIT_RESET;
    else if (reset_ok)
      lit <= 1'b1;
    else if (mode == MODE_LEG || mode == MODE_CUMULATIVE)
      lit <= 1'b1;
    else if (disp_ev)
      lit <= ~lit;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reset_locked <= 1'b0;
    else if (reset_ok)
      reset_locked <= 1'b0;
    else if (run_ev && mode == MODE_INTERRUPTED && !running)
      reset_locked <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timed <= 1'b0;
    else if (reset_ok)
      timed <= 1'b0;
    else if (run_ev)
      timed <= 1'b1;
  end

  // ==========================================================
  // time base and counter
  assign tick = running && presc == 32'(TICK_CYCLES - 1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      presc <= '0;
    else if (counter_clear || tick)
      presc <= '0;
    else if (running)
      presc <= presc + 32'h1;
  end

  time_counter u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .clear(counter_clear),
    .tick(tick),
    .minute_step(ev.minute_step_key),
    .hour_step(ev.hour_step_key),
    .count(count)
  );

  assign shown = hold ? held : count;

  // ==========================================================
  // display scan
  logic [31:0] slot_timer;
  logic [2:0] slot;
  logic [3:0] digit;
  logic digit_blank;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slot_timer <= '0;
      slot <= '0;
    end
    else if (slot_timer == 32'(SLOT_CYCLES - 1))
    begin
      slot_timer <= '0;
      slot <= slot + 3'h1;
    end
    else
      slot_timer <= slot_timer + 32'h1;
  end

  assign digit = shown[{slot, 2'b00} +: 4];

  // zero suppression works on digit pairs; hundredths always shown
  always_comb
  begin
    unique case (slot[2:1])
      2'd0: digit_blank = 1'b0;
      2'd1: digit_blank = shown[31:8] == '0;
      2'd2: digit_blank = shown[31:16] == '0;
      2'd3: digit_blank = shown[31:24] == '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      digit_strobe <= '0;
      segments <= '0;
    end
    else
    begin
      digit_strobe <= (lit && !digit_blank) ? 8'h01 << slot : 8'h00;
      segments <= seg_decode(digit);
    end
  end

  // ==========================================================
  // register read
  logic [31:0] status_word;

  always_comb
  begin
    status_word = '0;
    status_word[STAT_RUNNING_BIT] = running;
    status_word[STAT_HOLD_BIT] = hold;
    status_word[STAT_LIT_BIT] = lit;
    status_word[STAT_LOCKED_BIT] = reset_locked;
    status_word[STAT_MODE_LSB +: 2] = mode;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (setup_phase)
    begin
      if (paddr == STATUS_OFFSET)
        prdata <= status_word;
      else if (paddr == COUNT_OFFSET)
        prdata <= count;
      else if (paddr == SHOWN_OFFSET)
        prdata <= shown;
      else
        prdata <= '0;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_leg_catchup: assert property (disp_ev && mode == MODE_LEG && !run_ev
    |=> !hold)
    else $error("display key did not release leg hold");
  a_leg_lit: assert property (mode == MODE_LEG ##1 mode == MODE_LEG |-> lit)
    else $error("display blank in leg-restart mode");
  a_leg_reset: assert property (reset_ok && mode == MODE_LEG
    |=> count == '0 && !hold && !running)
    else $error("reset did not clear leg-restart state");
  a_cumul_start: assert property (run_ev && mode == MODE_CUMULATIVE && !running
    |=> running && !hold ##1 shown == count)
    else $error("cumulative start did not run live");
  a_cumul_freeze: assert property (run_ev && mode == MODE_CUMULATIVE && running
    |=> hold && running && held == $past(count))
    else $error("cumulative lap did not freeze total");
  a_cumul_catch: assert property (disp_ev && mode == MODE_CUMULATIVE && !run_ev
    |=> !hold)
    else $error("cumulative catch-up failed");
  a_cumul_lit: assert property (mode == MODE_CUMULATIVE [*2] |-> lit)
    else $error("display blank in cumulative mode");
  a_lock_reset: assert property (ev.reset_key && mode == MODE_INTERRUPTED
    && reset_locked && !run_ev |=> running == $past(running) && reset_locked)
    else $error("reset acted while locked");
  a_interr_toggle: assert property (run_ev && mode == MODE_INTERRUPTED
    |=> running != $past(running) && $past(count) == $past(shown))
    else $error("interrupted run/halt did not toggle");
  a_interr_blank: assert property (disp_ev && mode == MODE_INTERRUPTED
    |=> lit != $past(lit))
    else $error("display key did not toggle blanking");
  a_single_clear: assert property (run_ev && mode == MODE_SINGLE && !running && timed
    |=> count == '0 && running)
    else $error("single restart did not clear counter");
  a_leg_capture: assert property (run_ev && mode == MODE_LEG && running
    |=> held == $past(count) && count == '0 && running && hold)
    else $error("leg capture failed");
  a_halted_still: assert property (!running && !counter_clear
    && !ev.minute_step_key && !ev.hour_step_key |=> count == $past(count))
    else $error("count moved while halted");

  c_leg_capture: cover property (run_ev && mode == MODE_LEG && running);
  c_cumul_lap: cover property (run_ev && mode == MODE_CUMULATIVE && hold);
  c_locked_reset: cover property (ev.reset_key && mode == MODE_INTERRUPTED && reset_locked);
  c_single_restart: cover property (run_ev && mode == MODE_SINGLE && !running && timed);
endmodule

/* verilog/stopwatch_pkg.sv */
// shared constants and types for the stopwatch and 24-hour clock control block
// Summary of operation
// - leg-restart: display key drops the held leg
// - leg-restart: display always lit, blanking ignored
// - leg-restart: reset clears counter and display anytime
// - cumulative-lap: first run/halt starts, display live
// - cumulative-lap: second run/halt freezes display, counter runs
// - cumulative-lap: later run/halt loads running total
// - cumulative-lap: display key catches display up
// - cumulative-lap: display always lit
// - interrupted: reset key ignored once timing started
// - interrupted: second run/halt halts counter and display
// - interrupted: further run/halt alternately resume and halt
// - interrupted: display key toggles lit and blank
// - minute-step key adds exactly one minute
// - hour-step key adds exactly one hour
// - clock use: run/halt stops and resumes count
// - counter spans 24 hours in 0.01 s steps
// - single-event: restart after halt clears counter first
// - leg-restart: run/halt captures leg, clears, keeps running
// - leading zero digit pairs blanked automatically
// - hundredths strobe period 1.25 ms, 800 Hz scan
// - mode from select inputs, none high is leg-restart
// - reset clears all, shows 00, display on
// - time base divides clock down to 100 Hz
// - single-event clearing pulse far below 0.01 s
package stopwatch_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_PERIOD_NS = 10_000_000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int MUX_PERIOD_NS = 1_250_000;
  localparam int DIGIT_COUNT = 8;
  localparam int SLOT_CYCLES = MUX_PERIOD_NS / (CLK_PERIOD_NS * DIGIT_COUNT);
  // ==========================================================
  // count limits (bcd)
  localparam logic [7:0] LAST_HOUR = 8'h23;
  localparam logic [7:0] LAST_MINUTE = 8'h59;
  localparam logic [7:0] LAST_SECOND = 8'h59;
  localparam logic [7:0] LAST_HUNDREDTH = 8'h99;
  // ==========================================================
  // register map
  localparam logic [7:0] KEYCTL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] COUNT_OFFSET = 8'h08;
  localparam logic [7:0] SHOWN_OFFSET = 8'h0c;
  localparam int STAT_RUNNING_BIT = 0;
  localparam int STAT_HOLD_BIT = 1;
  localparam int STAT_LIT_BIT = 2;
  localparam int STAT_LOCKED_BIT = 3;
  localparam int STAT_MODE_LSB = 4;
  localparam logic LIT_RESET = 1'b1;
  // ==========================================================
  // types
  typedef struct packed {
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
    logic [7:0] hundredths;
  } time_t;
  typedef struct packed {
    logic run_halt_key;
    logic reset_key;
    logic display_key;
    logic minute_step_key;
    logic hour_step_key;
  } keys_t;
  typedef struct packed {
    logic single_sel;
    logic cumulative_sel;
    logic interrupted_sel;
  } mode_sel_t;
  typedef enum logic [1:0] {
    MODE_LEG,
    MODE_SINGLE,
    MODE_CUMULATIVE,
    MODE_INTERRUPTED
  } mode_t;
endpackage

/* verilog/time_counter.sv */
// bcd time-of-day counter, 0.01 s to 24 h, with minute and hour stepping
`timescale 1ns/1ps
module time_counter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic tick,
  input wire logic minute_step,
  input wire logic hour_step,
  output stopwatch_pkg::time_t count
);
  import stopwatch_pkg::*;

  // returns {carry, next pair}
  function automatic logic [8:0] pair_inc(input logic [7:0] p, input logic [7:0] last);
    logic [8:0] r;
    if (p == last)
      r = 9'h100;
    else if (p[3:0] == 4'h9)
      r = {1'b0, p[7:4] + 4'h1, 4'h0};
    else
      r = {1'b0, p[7:4], p[3:0] + 4'h1};
    return r;
  endfunction

  logic [8:0] inc_c;
  logic [8:0] inc_s;
  logic [8:0] inc_m;
  logic [8:0] inc_h;
  time_t next_count;

  assign inc_c = pair_inc(count.hundredths, LAST_HUNDREDTH);
  assign inc_s = pair_inc(count.seconds, LAST_SECOND);
  assign inc_m = pair_inc(count.minutes, LAST_MINUTE);
  assign inc_h = pair_inc(count.hours, LAST_HOUR);

  always_comb
  begin
    next_count = count;
    if (tick)
    begin
      next_count.hundredths = inc_c[7:0];
      if (inc_c[8])
      begin
        next_count.seconds = inc_s[7:0];
        if (inc_s[8])
        begin
          next_count.minutes = inc_m[7:0];
          if (inc_m[8])
            next_count.hours = inc_h[7:0];
        end
      end
    end
    // steps add to one field only, no carry
    if (minute_step)
      next_count.minutes = inc_m[7:0];
    if (hour_step)
      next_count.hours = inc_h[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= '0;
    else if (clear)
      count <= '0;
    else
      count <= next_count;
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_wrap_zero: assert property (tick && !clear && !minute_step && !hour_step
    && count == 32'h23595999 |=> count == '0)
    else $error("count did not wrap to zero");
  a_minute_step: assert property (minute_step && !hour_step && !tick && !clear
    |=> count.minutes == $past(inc_m[7:0]) && count.hours == $past(count.hours))
    else $error("minute step not exactly one");
  a_hour_step: assert property (hour_step && !minute_step && !tick && !clear
    |=> count.hours == $past(inc_h[7:0]) && count.minutes == $past(count.minutes))
    else $error("hour step not exactly one");
  a_count_hold: assert property (!tick && !clear && !minute_step && !hour_step
    |=> $stable(count))
    else $error("count moved without a tick");
endmodule
